// File: common/tx_fifo_ctl_pkg.sv
// Purpose: Constants and carrier types for the transmit elastic FIFO control.
// Assumes: One clock, mclk, that stands for the divided multiplier clock.

package tx_fifo_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] TX_FIFO_CONTROL_ADDR = 8'h03;
  localparam int         CTL_FLUSH_BIT        = 0;
  localparam int         CTL_AUTO_BIT         = 1;
  localparam int         STAT_OVF_BIT         = 2;
  localparam logic [1:0] CTL_RESET            = 2'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         FLUSH_MIN_CYCLES = 8;
  localparam int         FLUSH_MAX_CYCLES = 10;
  localparam logic [3:0] FLUSH_WAIT       = 4'h8;
  localparam int         FIFO_DEPTH       = 16;
  localparam int         LOW_RATE_DIVIDE  = 8;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_DRAIN
  } flush_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

// File: hw/tx_fifo_ctl.sv
// Purpose: Transmit elastic FIFO recovery, overflow and aux clock control.
// Assumes: Inputs are synchronous to mclk; mclk stands for the clock
//          divided from the multiplier, at twice the parallel word rate.
// Notes:   The FIFO data path lives elsewhere; this block tracks its level.
`timescale 1ns/100ps
`default_nettype none

module tx_fifo_ctl
  import tx_fifo_ctl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic                     mclk,             // Clock.
  input  wire logic                     srst,             // Sync reset.
  input  wire logic                     host_mode,        // 1 = host mode.
  input  wire logic                     fifo_flush_pin,   // Flush input.
  input  wire logic                     fifo_write,       // Word written.
  input  wire logic                     fifo_read,        // Word read.
  input  wire logic                     multiplier_lock_raw, // Lock sense.
  input  wire logic                     aux_clock_rate_select, // 1 = slow.
  input  wire tx_fifo_ctl_pkg::reg_req_s reg_req,         // Register write.
  input  wire logic [7:0]               reg_rd_addr,      // Read address.
  output logic [7:0]                    reg_rdata,        // Read data.
  output logic                          overflow_out,     // FIFO overflow.
  output logic                          multiplier_lock_flag, // Locked.
  output logic                          aux_clock_out,    // Aux clock.
  output logic                          fifo_ready        // Not flushing.
);
  import tx_fifo_ctl_pkg::*;

  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
  localparam logic [2:0] DIV_LAST = 3'(LOW_RATE_DIVIDE - 1);
  localparam int DRAIN_LO = FLUSH_MIN_CYCLES;
  localparam int DRAIN_HI = FLUSH_MAX_CYCLES;

  flush_state_e  state_q, state_d;
  logic [1:0]    ctl_q, ctl_d;
  logic [3:0]    drain_q, drain_d;
  logic [LW-1:0] level_q, level_d;
  logic [2:0]    div_q, div_d;
  logic          ovf_q, ovf_d;
  logic          aux_q, aux_d;
  logic          lock_q;
  logic          ready_q;
  logic [7:0]    rdata_q;

  // ----------------------------------------------------------------------
  // Flush request selection
  // ----------------------------------------------------------------------
  wire ctl_hit   = reg_req.wr && (reg_req.addr == TX_FIFO_CONTROL_ADDR);
  wire host_req  = ctl_q[CTL_FLUSH_BIT] || (ctl_q[CTL_AUTO_BIT] && ovf_q);
  wire flush_req = host_mode ? host_req
                             : fifo_flush_pin;
  wire running   = (state_q == ST_RUN);
  wire full      = (level_q == FULL_LEVEL);
  wire ovf_event = running && fifo_write && !fifo_read && full;
  wire drain_end = (state_q == ST_DRAIN) && (drain_q == FLUSH_WAIT - 4'h1);

  assign ctl_d = ctl_hit ? reg_req.data[1:0] : ctl_q;

  // ----------------------------------------------------------------------
  // Flush sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    drain_d = 4'h0;
    unique case (state_q)
      ST_RUN:
      begin
        if (flush_req)
          state_d = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (!flush_req)
          state_d = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        drain_d = drain_q + 4'h1;
        if (flush_req)
          state_d = ST_HOLD;
        else if (drain_end)
          state_d = ST_RUN;
      end
    endcase
  end

  // The level is only meaningful while running; a flush empties the FIFO.
  always_comb
  begin
    level_d = '0;
    if (running && !flush_req)
    begin
      level_d = level_q;
      if (fifo_write && !fifo_read && !full)
        level_d = level_q + LW'(1);
      else if (fifo_read && !fifo_write && level_q != '0)
        level_d = level_q - LW'(1);
    end
  end

  // Clearing on the hold state lets a flush input tied to overflow
  // release itself; the set term wins should both ever meet.
  assign ovf_d = ovf_event || (ovf_q && state_q != ST_HOLD);

  // ----------------------------------------------------------------------
  // Aux clock divider
  // ----------------------------------------------------------------------
  wire div_wrap = (div_q == DIV_LAST);
  assign div_d = (aux_clock_rate_select && !div_wrap) ? div_q + 3'h1 : 3'h0;
  assign aux_d = (!aux_clock_rate_select || div_wrap)
                 ? !aux_q : aux_q;

  wire [7:0] rd_word = {5'h0, ovf_q, ctl_q};
  wire [7:0] rdata_d = (reg_rd_addr == TX_FIFO_CONTROL_ADDR) ? rd_word : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= ST_HOLD;
      ctl_q   <= CTL_RESET;
      drain_q <= 4'h0;
      level_q <= '0;
      div_q   <= 3'h0;
      ovf_q   <= 1'b0;
      aux_q   <= 1'b0;
      lock_q  <= 1'b0;
      ready_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      ctl_q   <= ctl_d;
      drain_q <= drain_d;
      level_q <= level_d;
      div_q   <= div_d;
      ovf_q   <= ovf_d;
      aux_q   <= aux_d;
      lock_q  <= multiplier_lock_raw;
      ready_q <= (state_d == ST_RUN);
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata            = rdata_q;
  assign overflow_out         = ovf_q;
  assign multiplier_lock_flag = lock_q;
  assign aux_clock_out        = aux_q;
  assign fifo_ready           = ready_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_lock_follow: assert property (
    ##1 multiplier_lock_flag == $past(multiplier_lock_raw))
    else $error("lock flag does not follow the multiplier");
  chk_ovf_set: assert property (
    (state_q == ST_RUN && fifo_write && !fifo_read && full) |=> overflow_out)
    else $error("overflow not raised on a write to a full FIFO");
  chk_ovf_hold: assert property (
    (overflow_out && state_q != ST_HOLD) |=> overflow_out)
    else $error("overflow dropped before a flush was taken");
  chk_ovf_clear: assert property (
    (state_q == ST_HOLD) |=> !overflow_out)
    else $error("overflow still high after a flush was taken");
  chk_drain_time: assert property (
    (state_q == ST_HOLD && !flush_req) |->
      ##[DRAIN_LO:DRAIN_HI] (fifo_ready || flush_req))
    else $error("flush did not complete in eight to ten cycles");
  chk_drain_early: assert property (
    (state_q == ST_HOLD && !flush_req) |=> !fifo_ready [*7])
    else $error("FIFO ready too early after flush");
  chk_pin_ignored: assert property (
    (host_mode && state_q == ST_RUN && !ctl_q[CTL_FLUSH_BIT]
      && !(ctl_q[CTL_AUTO_BIT] && overflow_out)) |=> state_q != ST_HOLD)
    else $error("flush pin acted in host mode");
  chk_host_flush: assert property (
    (host_mode && state_q == ST_RUN && ctl_q[CTL_FLUSH_BIT])
      |=> (state_q == ST_HOLD && !fifo_ready))
    else $error("register flush bit did not flush");
  chk_auto_flush: assert property (
    (host_mode && state_q == ST_RUN && ctl_q[CTL_AUTO_BIT] && overflow_out)
      |=> state_q == ST_HOLD)
    else $error("auto recovery did not flush after overflow");
  chk_aux_fast: assert property (
    (!aux_clock_rate_select ##1 !aux_clock_rate_select)
      |-> aux_clock_out != $past(aux_clock_out))
    else $error("aux clock not at word rate");

  cov_overflow: cover property (ovf_event ##1 overflow_out);
  cov_auto: cover property (host_mode && ctl_q[CTL_AUTO_BIT] && ovf_event
    ##[1:20] fifo_ready);
  cov_slow: cover property (aux_clock_rate_select [*8] ##1 $changed(aux_q));

endmodule

`default_nettype wire

// File: testbench/tx_framer_model.sv
// Purpose: Downstream framer: writes words and drives the flush pin.
// Assumes: The flush pin is wired as overflow OR the framer's own request.
// Notes:   Combinational, so recovery starts the cycle overflow is seen.
`timescale 1ns/100ps
`default_nettype none

module tx_framer_model (
  input  wire logic overflow,  // Overflow seen.
  input  wire logic own_flush, // Framer's own reset request.
  input  wire logic send,      // Write a word.
  output logic      flush_pin, // To flush input.
  output logic      word_wr    // Word strobe.
);
  assign flush_pin = overflow | own_flush;
  assign word_wr   = send;
endmodule

`default_nettype wire

// File: testbench/tx_elastic_fifo_control_tb.sv
// Purpose: Self-checking bench for the transmit FIFO control.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Notes are queued by the driver and compared at the falling edge.
`timescale 1ns/100ps
`default_nettype none

module tx_elastic_fifo_control_tb;
  import tx_fifo_ctl_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [7:0] val;} note_s;
  logic mclk = 0, srst = 1, host = 0, own = 1, send = 0, rd = 0;
  logic lock_raw = 0, sel = 0, pin, wr, ovf, lock, aux, rdy, aux_p = 0;
  reg_req_s rq = '0;
  logic [7:0] ra = 8'h03, rdata, tog = 8'h00, base = 8'h00;
  note_s notes[$];
  note_s n;
  int errors = 0, checked = 0, cyc = 0, seed = 72146, i;

  tx_fifo_ctl dut (.mclk(mclk), .srst(srst), .host_mode(host),
    .fifo_flush_pin(pin), .fifo_write(wr), .fifo_read(rd),
    .multiplier_lock_raw(lock_raw), .aux_clock_rate_select(sel),
    .reg_req(rq), .reg_rd_addr(ra), .reg_rdata(rdata),
    .overflow_out(ovf), .multiplier_lock_flag(lock),
    .aux_clock_out(aux), .fifo_ready(rdy));
  tx_framer_model fm (.overflow(ovf), .own_flush(own), .send(send),
    .flush_pin(pin), .word_wr(wr));

  initial forever #5 mclk = ~mclk;

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic note(input logic [2:0] s, input logic [7:0] v);
    notes.push_back({s, v});
  endtask

  task automatic cmp_bit(input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t flag exp %b got %b", $time, e, g);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t byte exp %h got %h", $time, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    rq = '{wr: 1'b1, addr: a, data: d};
    tick(1);
    rq.wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    ra = a;
    tick(1);
  endtask

  task automatic fill();
    send = 1;
    tick(17);
    send = 0;
  endtask

  // A write and a read together at full, then a read and a refill, must
  // not overflow; the next lone write at full does.
  task automatic fill_rd();
    send = 1;
    tick(16);
    rd = 1;
    tick(1);
    send = 0;
    tick(1);
    send = 1;
    rd = 0;
    tick(1);
    note(3'h1, 8'h00);
    tick(1);
    send = 0;
  endtask

  task automatic wait_rdy();
    for (i = 0; i < 12 && rdy !== 1'b1; i++)
      tick(1);
  endtask

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge mclk)
  begin
    tog <= tog + 8'(aux !== aux_p);
    aux_p <= aux;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.sel)
        3'h0: cmp_bit(n.val[0], rdy);
        3'h1: cmp_bit(n.val[0], ovf);
        3'h2: cmp_bit(n.val[0], lock);
        3'h3: cmp_byte(n.val, rdata);
        default: cmp_byte(n.val, tog);
      endcase
    end
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    tick(8);
    srst = 0;
    own = 0;
    tick(8);
    note(3'h0, 8'h00);
    tick(1);
    note(3'h0, 8'h01);
    note(3'h3, 8'h00);
    fill_rd();
    note(3'h1, 8'h01);
    tick(1);
    note(3'h0, 8'h00);
    tick(1);
    note(3'h1, 8'h00);
    wait_rdy();
    note(3'h0, 8'h01);
    host = 1;
    own = 1;
    tick(3);
    note(3'h0, 8'h01);
    wreg(8'h03, 8'h01);
    tick(1);
    wreg(8'h05, 8'h00);
    tick(1);
    note(3'h0, 8'h00);
    note(3'h3, 8'h01);
    wreg(8'h03, 8'h02);
    rreg(8'h05);
    note(3'h3, 8'h00);
    wait_rdy();
    note(3'h0, 8'h01);
    fill();
    note(3'h1, 8'h01);
    tick(3);
    note(3'h1, 8'h00);
    note(3'h0, 8'h00);
    wait_rdy();
    note(3'h0, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      sel = k[0];
      tick(16);
      base = tog;
      tick(32);
      note(3'h4, base + (k ? 8'h04 : 8'h20));
    end
    repeat (8)
    begin
      lock_raw = 1'($random(seed));
      tick(1);
      note(3'h2, {7'h00, lock_raw});
    end
    tick(2);
    summarize();
  end
endmodule

`default_nettype wire
